// File: rtl/dfx_exec.sv
// decrement-file and decimal-adjust execution core with file memory
`timescale 1ns/1ps
// Behaviour
// - Decrement subtracts one from the file register and updates all five arithmetic flags.
// - With destination bit 0 the result goes to the working register only.
// - With destination bit 1 the result is written back to the addressed file register.
// - Bank bit 0 with extended set on uses index plus literal for addresses up to 95.
// - Bank bit 0 selects the access bank, bank bit 1 uses the bank select register.
// - Decimal adjust adds 6 to each nibble above 9 or with its carry, upper sets carry.
module dfx_exec #(
   parameter int ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   output logic instr_ready,
   output logic instr_done,
   input wire logic [3:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata
);
   localparam int DEPTH = 1 << ADDR_W;

   dfx_pkg::dfx_state_t st_q;
   logic [15:0] ir_q;
   logic [ADDR_W-1:0] ea_q;
   logic [7:0] opnd_q;
   logic [7:0] res_q;
   logic [4:0] nflags_q;
   logic [7:0] w_q;
   logic [4:0] status_q;
   logic [3:0] bank_q;
   logic ext_q;
   logic [11:0] idx_q;
   logic [11:0] ptr_q;
   logic [7:0] rdata_q;
   logic [7:0] mem [DEPTH];
   logic is_decrement;
   logic is_adjust;
   logic dest_f;
   dfx_alu_if alu_bus ();

   function automatic logic [ADDR_W-1:0] ea_f(input logic [7:0] f, input logic a,
      input logic ext, input logic [3:0] bank, input logic [11:0] idx);
      logic [11:0] r;
      r = {bank, f};
      if (!a) begin
         if (ext && f <= dfx_pkg::ACCESS_LIMIT) begin
            r = idx + {4'h0, f};
         end else if (f <= dfx_pkg::ACCESS_LIMIT) begin
            r = {dfx_pkg::ACCESS_LOW_BANK, f};
         end else begin
            r = {dfx_pkg::ACCESS_HIGH_BANK, f};
         end
      end
      return r[ADDR_W-1:0];
   endfunction

   // opcode decode
   assign is_decrement = (ir_q[15:10] == dfx_pkg::OP_DECREMENT_FILE_HI);
   assign is_adjust = (ir_q == dfx_pkg::OP_DECIMAL_ADJUST);
   assign dest_f = ir_q[dfx_pkg::DEST_BIT];

   assign instr_ready = (st_q == dfx_pkg::ST_IDLE);
   assign instr_done = (st_q == dfx_pkg::ST_Q4);
   assign bus_rdata = rdata_q;

   // phase sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= dfx_pkg::ST_IDLE;
      end else begin
         case (st_q)
            dfx_pkg::ST_IDLE: begin
               if (instr_valid) begin
                  st_q <= dfx_pkg::ST_Q1;
               end
            end
            dfx_pkg::ST_Q1: st_q <= dfx_pkg::ST_Q2;
            dfx_pkg::ST_Q2: st_q <= dfx_pkg::ST_Q3;
            dfx_pkg::ST_Q3: st_q <= dfx_pkg::ST_Q4;
            dfx_pkg::ST_Q4: st_q <= dfx_pkg::ST_IDLE;
            default: st_q <= dfx_pkg::ST_IDLE;
         endcase
      end
   end

   // instruction latch, address, operand and result
   always_ff @(posedge clk) begin
      if (rst) begin
         ir_q <= 16'h0000;
         ea_q <= '0;
         opnd_q <= 8'h00;
         res_q <= 8'h00;
         nflags_q <= dfx_pkg::STATUS_RST;
      end else begin
         if (st_q == dfx_pkg::ST_IDLE && instr_valid) begin
            ir_q <= instr;
         end
         if (st_q == dfx_pkg::ST_Q1) begin
            ea_q <= ea_f(ir_q[7:0], ir_q[dfx_pkg::BANK_BIT], ext_q, bank_q, idx_q);
         end
         if (st_q == dfx_pkg::ST_Q2) begin
            opnd_q <= is_adjust ? w_q : mem[ea_q];
         end
         if (st_q == dfx_pkg::ST_Q3) begin
            res_q <= alu_bus.y;
            nflags_q <= alu_bus.flags_out;
         end
      end
   end

   assign alu_bus.decimal_adjust_op = is_adjust;
   assign alu_bus.a = opnd_q;
   assign alu_bus.flags_in = status_q;

   dfx_alu i_dfx_alu (
      .io(alu_bus)
   );

   // working register and flags, instruction write wins over software
   always_ff @(posedge clk) begin
      if (rst) begin
         w_q <= dfx_pkg::W_RST;
         status_q <= dfx_pkg::STATUS_RST;
      end else if (st_q == dfx_pkg::ST_Q4 && (is_decrement || is_adjust)) begin
         status_q <= nflags_q;
         if (is_adjust || !dest_f) begin
            w_q <= res_q;
         end
      end else if (bus_wr) begin
         if (bus_addr == dfx_pkg::REG_W) begin
            w_q <= bus_wdata;
         end
         if (bus_addr == dfx_pkg::REG_STATUS) begin
            status_q <= bus_wdata[4:0];
         end
      end
   end

   // addressing configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         bank_q <= dfx_pkg::BANK_RST;
         ext_q <= dfx_pkg::CTRL_EXT_RST;
         idx_q <= dfx_pkg::IDX_RST;
         ptr_q <= dfx_pkg::PTR_RST;
      end else if (bus_wr) begin
         case (bus_addr)
            dfx_pkg::REG_BANK: bank_q <= bus_wdata[3:0];
            dfx_pkg::REG_CTRL: ext_q <= bus_wdata[dfx_pkg::CTRL_EXT_BIT];
            dfx_pkg::REG_IDX_L: idx_q[7:0] <= bus_wdata;
            dfx_pkg::REG_IDX_H: idx_q[11:8] <= bus_wdata[3:0];
            dfx_pkg::REG_PTR_L: ptr_q[7:0] <= bus_wdata;
            dfx_pkg::REG_PTR_H: ptr_q[11:8] <= bus_wdata[3:0];
            default: ;
         endcase
      end
   end

   // file memory, instruction write wins over software
   always_ff @(posedge clk) begin
      if (st_q == dfx_pkg::ST_Q4 && is_decrement && dest_f) begin
         mem[ea_q] <= res_q;
      end else if (bus_wr && bus_addr == dfx_pkg::REG_MEM) begin
         mem[ptr_q[ADDR_W-1:0]] <= bus_wdata;
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (bus_rd) begin
         case (bus_addr)
            dfx_pkg::REG_W: rdata_q <= w_q;
            dfx_pkg::REG_STATUS: rdata_q <= {3'h0, status_q};
            dfx_pkg::REG_BANK: rdata_q <= {4'h0, bank_q};
            dfx_pkg::REG_CTRL: rdata_q <= {7'h00, ext_q};
            dfx_pkg::REG_IDX_L: rdata_q <= idx_q[7:0];
            dfx_pkg::REG_IDX_H: rdata_q <= {4'h0, idx_q[11:8]};
            dfx_pkg::REG_PTR_L: rdata_q <= ptr_q[7:0];
            dfx_pkg::REG_PTR_H: rdata_q <= {4'h0, ptr_q[11:8]};
            dfx_pkg::REG_MEM: rdata_q <= mem[ptr_q[ADDR_W-1:0]];
            dfx_pkg::REG_STATE: rdata_q <= {3'h0, st_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   a_dec_result: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q3 && is_decrement) |=> res_q == $past(opnd_q) - dfx_pkg::DEC_ONE)
      else $error("decrement result wrong");
   a_dec_zero: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q4 && is_decrement)
      |=> status_q[dfx_pkg::FLAG_Z] == ($past(res_q) == 8'h00))
      else $error("zero flag wrong after decrement");
   a_w_dest: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q4 && is_decrement && !dest_f) |=> w_q == $past(res_q))
      else $error("working register not loaded");
   a_file_dest: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q4 && is_decrement && dest_f)
      |=> mem[$past(ea_q)] == $past(res_q) && w_q == $past(w_q))
      else $error("file register not written back");
   a_indexed_addr: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q1 && !ir_q[dfx_pkg::BANK_BIT] && ext_q
      && ir_q[7:0] <= dfx_pkg::ACCESS_LIMIT)
      |=> ea_q == ADDR_W'($past(idx_q) + {4'h0, $past(ir_q[7:0])}))
      else $error("indexed address wrong");
   a_bank_select: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q1 && ir_q[dfx_pkg::BANK_BIT])
      |=> ea_q == {$past(bank_q), $past(ir_q[7:0])})
      else $error("bank select address wrong");
   a_adjust_carry: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q3 && is_adjust && opnd_q[7:4] > dfx_pkg::BCD_MAX)
      |-> ##2 status_q[dfx_pkg::FLAG_C])
      else $error("decimal adjust carry not set");
   a_four_phase: assert property (@(posedge clk) disable iff (rst)
      (st_q == dfx_pkg::ST_Q1) |=> st_q == dfx_pkg::ST_Q2 ##1 st_q == dfx_pkg::ST_Q3
      ##1 st_q == dfx_pkg::ST_Q4 ##1 st_q == dfx_pkg::ST_IDLE)
      else $error("phase sequence broken");
endmodule

// File: rtl/dfx_pkg.sv
// shared constants and types for the decrement-file execution block
package dfx_pkg;
   // register map on the plain software port
   localparam logic [3:0] REG_W = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_BANK = 4'h2;
   localparam logic [3:0] REG_CTRL = 4'h3;
   localparam logic [3:0] REG_IDX_L = 4'h4;
   localparam logic [3:0] REG_IDX_H = 4'h5;
   localparam logic [3:0] REG_PTR_L = 4'h6;
   localparam logic [3:0] REG_PTR_H = 4'h7;
   localparam logic [3:0] REG_MEM = 4'h8;
   localparam logic [3:0] REG_STATE = 4'h9;
   // reset values
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic CTRL_EXT_RST = 1'b0;
   localparam logic [11:0] IDX_RST = 12'h000;
   localparam logic [11:0] PTR_RST = 12'h000;
   // status flag positions and the control extended bit
   localparam int FLAG_C = 0;
   localparam int FLAG_NIBBLE_CARRY = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_SIGNED_OVERFLOW = 3;
   localparam int FLAG_N = 4;
   localparam int CTRL_EXT_BIT = 0;
   // opcode fields
   localparam logic [5:0] OP_DECREMENT_FILE_HI = 6'h01;
   localparam logic [15:0] OP_DECIMAL_ADJUST = 16'h0007;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   // addressing
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // arithmetic constants
   localparam logic [7:0] DEC_ONE = 8'h01;
   localparam logic [7:0] SIGN_MIN = 8'h80;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [8:0] BCD_FIX_LO = 9'h006;
   localparam logic [8:0] BCD_FIX_HI = 9'h060;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_Q1 = 5'b00010,
      ST_Q2 = 5'b00100,
      ST_Q3 = 5'b01000,
      ST_Q4 = 5'b10000
   } dfx_state_t;
endpackage

// File: rtl/dfx_alu_if.sv
// operand and result bundle between the sequencer and the arithmetic unit
`timescale 1ns/1ps
interface dfx_alu_if;
   logic decimal_adjust_op;
   logic [7:0] a;
   logic [4:0] flags_in;
   logic [7:0] y;
   logic [4:0] flags_out;
   modport exec (output decimal_adjust_op, output a, output flags_in, input y, input flags_out);
   modport alu (input decimal_adjust_op, input a, input flags_in, output y, output flags_out);
endinterface

// File: rtl/dfx_alu.sv
// decrement and decimal adjust arithmetic
`timescale 1ns/1ps
module dfx_alu (
   dfx_alu_if.alu io
);
   logic [7:0] dec;
   logic [8:0] t;
   logic [4:0] f;

   assign dec = io.a - dfx_pkg::DEC_ONE;

   always_comb begin
      f = io.flags_in;
      t = {1'b0, io.a};
      if (io.decimal_adjust_op) begin
         if (t[3:0] > dfx_pkg::BCD_MAX || io.flags_in[dfx_pkg::FLAG_NIBBLE_CARRY]) begin
            t = t + dfx_pkg::BCD_FIX_LO;
         end
         if (t[7:4] > dfx_pkg::BCD_MAX || io.flags_in[dfx_pkg::FLAG_C] || t[8]) begin
            t = t + dfx_pkg::BCD_FIX_HI;
            f[dfx_pkg::FLAG_C] = 1'b1;
         end
      end else begin
         t = {1'b0, dec};
         // carry and nibble carry mean no borrow
         f[dfx_pkg::FLAG_C] = (io.a != 8'h00);
         f[dfx_pkg::FLAG_NIBBLE_CARRY] = (io.a[3:0] != 4'h0);
         f[dfx_pkg::FLAG_Z] = (dec == 8'h00);
         f[dfx_pkg::FLAG_SIGNED_OVERFLOW] = (io.a == dfx_pkg::SIGN_MIN);
         f[dfx_pkg::FLAG_N] = dec[7];
      end
   end

   assign io.y = t[7:0];
   assign io.flags_out = f;
endmodule

// File: sim/dfx_exec_bench.sv
// self-checking bench for the decrement-file execution block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dfx_exec_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic instr_ready;
   logic instr_done;
   logic [3:0] bus_addr = 4'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   int error_cnt = 0;
   int samples_checked = 0;
   dfx_exec #(.ADDR_W(12)) i_dfx_exec (.clk(clk), .rst(rst), .instr_valid(instr_valid),
      .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      `CHK(nm, e, bus_rdata)
   endtask
   task automatic mem(input logic [11:0] a, input logic [7:0] d);
      wr(dfx_pkg::REG_PTR_L, a[7:0]);
      wr(dfx_pkg::REG_PTR_H, {4'h0, a[11:8]});
      wr(dfx_pkg::REG_MEM, d);
   endtask
   task automatic mchk(input logic [11:0] a, input logic [7:0] e, input string nm);
      wr(dfx_pkg::REG_PTR_L, a[7:0]);
      wr(dfx_pkg::REG_PTR_H, {4'h0, a[11:8]});
      rd(dfx_pkg::REG_MEM, e, nm);
   endtask
   // one instruction: taken at c0, done in c3, ready again in c4
   task automatic exec(input logic [15:0] ins);
      int k;
      @(posedge clk);
      instr <= ins;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      `CHK("ready low", 1'b0, instr_ready)
      for (k = 1; k < 10; k++) begin
         @(posedge clk);
         #1;
         if (instr_done === 1'b1) break;
      end
      `CHK("done cycle", 3, k)
      @(posedge clk);
      #1;
      `CHK("ready again", 1'b1, instr_ready)
      `CHK("done pulse", 1'b0, instr_done)
   endtask
   task automatic t_reset();
      rd(dfx_pkg::REG_W, 8'h00, "w reset");
      rd(dfx_pkg::REG_STATUS, 8'h00, "status reset");
      rd(dfx_pkg::REG_BANK, 8'h00, "bank reset");
      rd(dfx_pkg::REG_CTRL, 8'h00, "ctrl reset");
      rd(dfx_pkg::REG_IDX_H, 8'h00, "idx reset");
      rd(dfx_pkg::REG_STATE, 8'h01, "state idle");
      rd(4'hF, 8'h00, "unmapped");
   endtask
   task automatic t_bank_writeback();
      wr(dfx_pkg::REG_BANK, 8'h03);
      mem(12'h345, 8'h80);
      mem(12'h045, 8'h22);
      exec(16'h0745);
      mchk(12'h345, 8'h7F, "banked result");
      mchk(12'h045, 8'h22, "access untouched");
      rd(dfx_pkg::REG_W, 8'h00, "w kept");
      rd(dfx_pkg::REG_STATUS, 8'h09, "flags 80h");
   endtask
   task automatic t_to_w();
      mem(12'h010, 8'h00);
      exec(16'h0410);
      rd(dfx_pkg::REG_W, 8'hFF, "w result");
      mchk(12'h010, 8'h00, "source kept");
      rd(dfx_pkg::REG_STATUS, 8'h10, "flags 00h");
   endtask
   task automatic t_access_high();
      mem(12'hF80, 8'h01);
      exec(16'h0680);
      mchk(12'hF80, 8'h00, "access high");
      rd(dfx_pkg::REG_STATUS, 8'h07, "flags 01h");
   endtask
   task automatic t_indexed();
      wr(dfx_pkg::REG_CTRL, 8'h01);
      wr(dfx_pkg::REG_IDX_L, 8'h23);
      wr(dfx_pkg::REG_IDX_H, 8'h01);
      mem(12'h128, 8'h11);
      mem(12'h005, 8'h44);
      exec(16'h0605);
      mchk(12'h128, 8'h10, "indexed");
      mchk(12'h005, 8'h44, "plain kept");
      rd(dfx_pkg::REG_STATUS, 8'h03, "flags 11h");
      mem(12'h182, 8'h02);
      exec(16'h065F);
      mchk(12'h182, 8'h01, "indexed top");
      mem(12'hF60, 8'h05);
      exec(16'h0660);
      mchk(12'hF60, 8'h04, "above limit");
      wr(dfx_pkg::REG_CTRL, 8'h00);
   endtask
   task automatic t_decimal_adjust();
      logic [7:0] ins [3] = '{8'hA5, 8'hCE, 8'h22};
      logic [7:0] outs [3] = '{8'h05, 8'h34, 8'h88};
      logic [7:0] st_in [3] = '{8'h00, 8'h00, 8'h03};
      logic [7:0] st_out [3] = '{8'h01, 8'h01, 8'h03};
      for (int i = 0; i < 3; i++) begin
         wr(dfx_pkg::REG_W, ins[i]);
         wr(dfx_pkg::REG_STATUS, st_in[i]);
         exec(dfx_pkg::OP_DECIMAL_ADJUST);
         rd(dfx_pkg::REG_W, outs[i], "adjusted w");
         rd(dfx_pkg::REG_STATUS, st_out[i], "adjust carry");
      end
   endtask
   // offer held through the busy phases must not start a second run
   task automatic t_busy_refused();
      mem(12'h020, 8'h10);
      @(posedge clk);
      instr <= 16'h0620;
      instr_valid <= 1'b1;
      repeat (4) @(posedge clk);
      instr_valid <= 1'b0;
      repeat (4) @(posedge clk);
      mchk(12'h020, 8'h0F, "busy refused");
   endtask
   // read data stand one cycle only
   task automatic t_read_pulse();
      wr(dfx_pkg::REG_PTR_L, 8'h5A);
      rd(dfx_pkg::REG_PTR_L, 8'h5A, "ptr low");
      @(posedge clk);
      #1;
      `CHK("read data one cycle", 8'h00, bus_rdata)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_bank_writeback();
      t_to_w();
      t_access_high();
      t_indexed();
      t_decimal_adjust();
      t_busy_refused();
      t_read_pulse();
      repeat (2) @(posedge clk);
      close_out();
   end
   initial begin
      #(40 * 20000);
      error_cnt++;
      close_out();
   end
endmodule
